//--- pwmaq_top.sv
// pwm timebase, compare and action qualifier with apb registers
// Function
// - up mode period is period_value plus one
// - up-down mode period is twice period_value
// - pulse set at compare a, cleared compare b
// - toggle on zero inverts once per period
// - up-down set up, clear down, symmetric
// - output b cleared up, set down
// - set on a up, clear on b down
// - clear zero, set period gives 50% wave in up-down mode
// - compare uses active copies, never shadows
// - up mode wraps period to zero next tick
//
// Implementation choices: register access over APB and the register offsets.
`include "pwmaq_defines.svh"

module pwmaq_top
    import pwmaq_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic        pclk,     // system clock, also timebase tick
    input  wire logic        presetn,  // async reset, active low
    input  wire logic        ce,       // clock enable, freezes all state
    input  wire logic        psel,     // apb select
    input  wire logic        penable,  // apb access phase
    input  wire logic        pwrite,   // apb direction
    input  wire logic [7:0]  paddr,    // apb byte address
    input  wire logic [31:0] pwdata,   // apb write data
    output logic      [31:0] prdata,   // apb read data
    output logic             pready,   // apb ready
    output logic             pslverr,  // apb error, unmapped address
    output logic             output_a, // pwm output a
    output logic             output_b  // pwm output b
);

    // ======================================================
    // parameter check
    if (CNT_W < 2 || CNT_W > 16) begin : g_bad_width
        $error("CNT_W must lie between 2 and 16");
    end

    // ======================================================
    // state
    logic [2:0]              timebase_control;
    logic [3:0]              compare_control;
    logic [`PWMAQ_ACT_W-1:0] action_control_a;
    logic [`PWMAQ_ACT_W-1:0] action_control_b;
    logic [CNT_W-1:0]        period_shadow;
    logic [CNT_W-1:0]        period_value;
    logic [CNT_W-1:0]        cmp_a_shadow;
    logic [CNT_W-1:0]        compare_value_a;
    logic [CNT_W-1:0]        cmp_b_shadow;
    logic [CNT_W-1:0]        compare_value_b;
    logic [CNT_W-1:0]        timebase_count;
    pwmaq_dir_t              dir;

    // apply one action to the present output level
    function automatic logic act_apply(input logic cur,
                                       input logic [1:0] act);
        unique case (pwmaq_action_t'(act))
            PWMAQ_ACT_NONE:   act_apply = cur;
            PWMAQ_ACT_LOW:    act_apply = 1'b0;
            PWMAQ_ACT_HIGH:   act_apply = 1'b1;
            PWMAQ_ACT_INVERT: act_apply = ~cur;
        endcase
    endfunction

    // resolve all events of one tick; later events override earlier
    function automatic logic qualify(input logic cur,
                                     input logic [`PWMAQ_ACT_W-1:0] ctl,
                                     input logic [5:0] ev);
        logic v;
        v = cur;
        for (int i = 0; i < 6; i++) begin
            if (ev[i]) begin
                v = act_apply(v, ctl[2*i +: 2]);
            end
        end
        qualify = v;
    endfunction

    // ======================================================
    // apb decode
    wire         acc      = psel & penable;
    wire         done     = acc & pready;
    wire         wr_en    = done & pwrite;
    wire         mapped   = (paddr[1:0] == 2'b00) &&
                            (paddr <= `PWMAQ_OFS_STATUS);
    wire         wr_tb    = wr_en && paddr == `PWMAQ_OFS_TB_CTRL;
    wire         wr_prd   = wr_en && paddr == `PWMAQ_OFS_PERIOD;
    wire         wr_ca    = wr_en && paddr == `PWMAQ_OFS_CMP_A;
    wire         wr_cb    = wr_en && paddr == `PWMAQ_OFS_CMP_B;
    wire         wr_cc    = wr_en && paddr == `PWMAQ_OFS_CMP_CTRL;
    wire         wr_aa    = wr_en && paddr == `PWMAQ_OFS_ACT_A;
    wire         wr_ab    = wr_en && paddr == `PWMAQ_OFS_ACT_B;
    wire [CNT_W-1:0] wdat = pwdata[CNT_W-1:0];

    // read mux; unused upper bits read zero
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            `PWMAQ_OFS_TB_CTRL:  rd_mux[2:0] = timebase_control;
            `PWMAQ_OFS_PERIOD:   rd_mux[CNT_W-1:0] = period_shadow;
            `PWMAQ_OFS_CMP_A:    rd_mux[CNT_W-1:0] = cmp_a_shadow;
            `PWMAQ_OFS_CMP_B:    rd_mux[CNT_W-1:0] = cmp_b_shadow;
            `PWMAQ_OFS_CMP_CTRL: rd_mux[3:0] = compare_control;
            `PWMAQ_OFS_ACT_A:    rd_mux[`PWMAQ_ACT_W-1:0] = action_control_a;
            `PWMAQ_OFS_ACT_B:    rd_mux[`PWMAQ_ACT_W-1:0] = action_control_b;
            `PWMAQ_OFS_STATUS: begin
                rd_mux[CNT_W-1:0]         = timebase_count;
                rd_mux[`PWMAQ_ST_DIR_BIT]  = dir;
                rd_mux[`PWMAQ_ST_OUTA_BIT] = output_a;
                rd_mux[`PWMAQ_ST_OUTB_BIT] = output_b;
            end
            default:             rd_mux = 32'h0000_0000;
        endcase
    end

    // ======================================================
    // counter control decode
    wire run      = timebase_control[`PWMAQ_TB_RUN_BIT];
    wire updown   = timebase_control[`PWMAQ_TB_DIR_BIT] ==
                    PWMAQ_COUNT_UP_THEN_DOWN;
    wire at_zero  = timebase_count == '0;
    wire at_prd   = timebase_count == period_value;
    // effective direction: turning points count as their own slope
    wire going_up = !updown || (at_zero ? 1'b1 :
                    at_prd ? 1'b0 : dir == PWMAQ_DIR_UP);

    // next count: up mode wraps, up-down reverses at both ends
    logic [CNT_W-1:0] next_count;
    pwmaq_dir_t       next_dir;
    always_comb begin
        next_dir   = dir;
        next_count = timebase_count + 1'b1;
        if (!updown) begin
            next_dir = PWMAQ_DIR_UP;
            if (timebase_count >= period_value) begin
                next_count = '0;
            end
        end else if (at_prd && !at_zero) begin
            next_dir   = PWMAQ_DIR_DOWN;
            next_count = timebase_count - 1'b1;
        end else if (at_zero) begin
            next_dir   = PWMAQ_DIR_UP;
            next_count = at_prd ? '0 : timebase_count + 1'b1;
        end else if (dir == PWMAQ_DIR_DOWN) begin
            next_count = timebase_count - 1'b1;
        end
    end

    // ======================================================
    // events on the active copies, order zero..cbd
    wire match_a = timebase_count == compare_value_a;
    wire match_b = timebase_count == compare_value_b;
    wire [5:0] events = run ? {match_b & !going_up, match_b & going_up,
                               match_a & !going_up, match_a & going_up,
                               at_prd, at_zero} : 6'h00;

    // shadow load points: 0 loads at zero, 1 at period
    wire load_a = compare_control[`PWMAQ_CC_A_LOAD_BIT] ? at_prd : at_zero;
    wire load_b = compare_control[`PWMAQ_CC_B_LOAD_BIT] ? at_prd : at_zero;
    wire imm_a  = compare_control[`PWMAQ_CC_A_MODE_BIT];
    wire imm_b  = compare_control[`PWMAQ_CC_B_MODE_BIT];
    wire imm_p  = timebase_control[`PWMAQ_TB_PERIOD_LOAD_SELECT_BIT];

    // ======================================================
    // apb handshake: one wait state, data registered with ready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready  <= acc & ~pready;
            prdata  <= (acc & ~pready & ~pwrite) ? rd_mux : 32'h0000_0000;
            pslverr <= acc & ~pready & ~mapped;
        end
    end

    // software-written control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timebase_control <= `PWMAQ_RST_TB_CTRL;
            compare_control  <= `PWMAQ_RST_CMP_CTRL;
            action_control_a <= `PWMAQ_RST_ACT;
            action_control_b <= `PWMAQ_RST_ACT;
            period_shadow    <= '0;
            cmp_a_shadow     <= '0;
            cmp_b_shadow     <= '0;
        end else if (ce) begin
            if (wr_tb) timebase_control <= pwdata[2:0];
            if (wr_cc) compare_control  <= pwdata[3:0];
            if (wr_aa) action_control_a <= pwdata[`PWMAQ_ACT_W-1:0];
            if (wr_ab) action_control_b <= pwdata[`PWMAQ_ACT_W-1:0];
            if (wr_prd) period_shadow   <= wdat;
            if (wr_ca) cmp_a_shadow     <= wdat;
            if (wr_cb) cmp_b_shadow     <= wdat;
        end
    end

    // active copies: immediate mode follows the shadow at once,
    // shadow mode waits for the load point so a period never sees
    // a half-updated compare
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_value    <= '0;
            compare_value_a <= '0;
            compare_value_b <= '0;
        end else if (ce) begin
            if (imm_p || (run && at_zero)) period_value <= period_shadow;
            if (imm_a || (run && load_a)) begin
                compare_value_a <= cmp_a_shadow;
            end
            if (imm_b || (run && load_b)) begin
                compare_value_b <= cmp_b_shadow;
            end
        end
    end

    // timebase counter, frozen while stopped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timebase_count <= '0;
            dir            <= PWMAQ_DIR_UP;
        end else if (ce && run) begin
            timebase_count <= next_count;
            dir            <= next_dir;
        end
    end

    // action qualifier: both outputs share one event vector
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_a <= 1'b0;
            output_b <= 1'b0;
        end else if (ce) begin
            output_a <= qualify(output_a, action_control_a, events);
            output_b <= qualify(output_b, action_control_b, events);
        end
    end

endmodule

//--- pwmaq_defines.svh
// register offsets, field positions and reset values of the pwm block
`ifndef PWMAQ_DEFINES_SVH
`define PWMAQ_DEFINES_SVH

// ==========================================================
// register byte offsets
`define PWMAQ_OFS_TB_CTRL   8'h00
`define PWMAQ_OFS_PERIOD    8'h04
`define PWMAQ_OFS_CMP_A     8'h08
`define PWMAQ_OFS_CMP_B     8'h0C
`define PWMAQ_OFS_CMP_CTRL  8'h10
`define PWMAQ_OFS_ACT_A     8'h14
`define PWMAQ_OFS_ACT_B     8'h18
`define PWMAQ_OFS_STATUS    8'h1C

// ==========================================================
// timebase_control fields
`define PWMAQ_TB_DIR_BIT    0
`define PWMAQ_TB_RUN_BIT    1
`define PWMAQ_TB_PERIOD_LOAD_SELECT_BIT  2

// compare_control fields
`define PWMAQ_CC_A_MODE_BIT 0
`define PWMAQ_CC_B_MODE_BIT 1
`define PWMAQ_CC_A_LOAD_BIT 2
`define PWMAQ_CC_B_LOAD_BIT 3

// status fields
`define PWMAQ_ST_DIR_BIT    16
`define PWMAQ_ST_OUTA_BIT   17
`define PWMAQ_ST_OUTB_BIT   18

// action field positions, two bits each
`define PWMAQ_ACT_ZERO      0
`define PWMAQ_ACT_PRD       2
`define PWMAQ_ACT_CAU       4
`define PWMAQ_ACT_CAD       6
`define PWMAQ_ACT_CBU       8
`define PWMAQ_ACT_CBD       10
`define PWMAQ_ACT_W         12

// ==========================================================
// reset values
`define PWMAQ_RST_TB_CTRL   3'h0
`define PWMAQ_RST_CMP_CTRL  4'h0
`define PWMAQ_RST_ACT       12'h000

`endif

//--- pwmaq_pkg.sv
// types shared by the pwm action-qualifier block
package pwmaq_pkg;

    // ======================================================
    // per-event output action
    typedef enum logic [1:0] {
        PWMAQ_ACT_NONE   = 2'b00,
        PWMAQ_ACT_LOW    = 2'b01,
        PWMAQ_ACT_HIGH   = 2'b10,
        PWMAQ_ACT_INVERT = 2'b11
    } pwmaq_action_t;

    // counter mode
    typedef enum logic {
        PWMAQ_COUNT_UP_ONLY     = 1'b0,
        PWMAQ_COUNT_UP_THEN_DOWN = 1'b1
    } pwmaq_mode_t;

    // counter direction state
    typedef enum logic {
        PWMAQ_DIR_UP   = 1'b0,
        PWMAQ_DIR_DOWN = 1'b1
    } pwmaq_dir_t;

endpackage

//--- pwmaq_sva.sv
// port-level assertions for the pwm action-qualifier block
module pwmaq_sva (
    input wire logic        pclk,     // clock
    input wire logic        presetn,  // reset, active low
    input wire logic        ce,       // clock enable
    input wire logic        psel,     // apb select
    input wire logic        penable,  // apb access phase
    input wire logic        pwrite,   // apb direction
    input wire logic [7:0]  paddr,    // apb address
    input wire logic [31:0] pwdata,   // apb write data
    input wire logic [31:0] prdata,   // apb read data
    input wire logic        pready,   // apb ready
    input wire logic        pslverr,  // apb error
    input wire logic        output_a, // pwm output a
    input wire logic        output_b  // pwm output b
);
    timeunit 1ns / 1ns;
    // ============
    // apb answer and output freeze
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // unaligned words are refused just like holes above the map
    wire bad_addr = (paddr > 8'h1C) || (paddr[1:0] != 2'h0);
    chk_one_wait: assert property (psel && penable && !pready && ce |=> pready)
        else $error("pready missing after one wait state");
    chk_ready_pulse: assert property (pready && ce |=> !pready)
        else $error("pready longer than one cycle");
    chk_ready_qual: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    chk_err_unmapped: assert property (pready && bad_addr |-> pslverr)
        else $error("unmapped access not refused");
    chk_err_mapped: assert property (pready && !bad_addr |-> !pslverr)
        else $error("mapped access refused");
    chk_err_rdata: assert property (pready && pslverr && !pwrite |-> !prdata)
        else $error("refused read returned data");
    chk_freeze_out: assert property (!ce |=>
                                     $stable(output_a) && $stable(output_b))
        else $error("output moved with clock enable low");
    chk_reset_quiet: assert property ($rose(presetn) |->
                                      !output_a && !output_b)
        else $error("output high after reset");
    cov_write: cover property (pready && pwrite && !pslverr);
    cov_refused: cover property (pready && pslverr);
    cov_rise_a: cover property ($rose(output_a));
endmodule
bind pwmaq_top pwmaq_sva u_sva (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .output_a(output_a), .output_b(output_b));

//--- pwmaq_gate_model.sv
// gate driver model: measures period and high time of one gate command
module pwmaq_gate_model (
    input  wire logic pclk,    // system clock
    input  wire logic presetn, // reset, active low
    input  wire logic gate,    // gate command from the pwm block
    output int        period,  // cycles between rising edges
    output int        high     // cycles of the last high phase
);
    timeunit 1ns / 1ns;
    int   cnt;
    logic prev;
    // ============
    // edge timing; counts pclk edges so ce must stay high while measuring
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            prev <= 1'h0;
            period <= 0;
            high <= 0;
        end else begin
            prev <= gate;
            cnt <= (gate && !prev) ? 0 : cnt + 1;
            if (gate && !prev) period <= cnt + 1;
            if (!gate && prev) high <= cnt + 1;
        end
    end
endmodule

//--- pwmaq_top_tb.sv
// self-checking bench for the pwm action-qualifier block
module pwmaq_top_tb;
    timeunit 1ns / 1ns;
    logic        pclk, presetn, ce, psel, penable, pwrite;
    logic        pready, pslverr, output_a, output_b;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    int          err_count = 0, n_checks = 0, cyc = 0;
    int          prd_a, hi_a, prd_b, hi_b;

    pwmaq_top DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .output_a(output_a), .output_b(output_b));
    pwmaq_gate_model u_gate_a (.pclk(pclk), .presetn(presetn),
        .gate(output_a), .period(prd_a), .high(hi_a));
    pwmaq_gate_model u_gate_b (.pclk(pclk), .presetn(presetn),
        .gate(output_b), .period(prd_b), .high(hi_b));

    // ============
    // clock and hang guard
    initial begin
        pclk = 1'h0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_count++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk32(input logic [31:0] got, exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask
    // ============
    // apb master: holds the request until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic ex_er = 1'h0);
        logic [31:0] rd;
        logic        er;
        apb(1'h1, a, d, rd, er);
        chk32({31'h0, er}, {31'h0, ex_er}, "write error flag");
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
                       input logic ex_er = 1'h0);
        logic [31:0] rd;
        logic        er;
        apb(1'h0, a, 32'h0, rd, er);
        chk32(rd, exp, "read data");
        chk32({31'h0, er}, {31'h0, ex_er}, "read error flag");
    endtask
    // waits for the waveform to settle, then judges both gates
    task automatic measure(input int cycles, pa, ha, pb, hb);
        repeat (cycles) @(posedge pclk);
        chk32(prd_a, pa, "period a");
        chk32(hi_a, ha, "high a");
        chk32(prd_b, pb, "period b");
        chk32(hi_b, hb, "high b");
    endtask

    // ============
    // scenarios
    task automatic t_regs();
        for (int a = 0; a < 32; a += 4) rdc(8'(a), 32'h0);
        rdc(8'h20, 32'h0, 1'h1);
        rdc(8'h06, 32'h0, 1'h1);
        wr(8'h24, 32'hFFFFFFFF, 1'h1);
        wr(8'h14, 32'hFFFFFFFF);
        rdc(8'h14, 32'h00000FFF);
    endtask
    task automatic t_up();
        wr(8'h00, 32'h4);      // immediate period load while stopped
        wr(8'h04, 32'h258);    // period 600
        wr(8'h08, 32'hC8);     // compare a 200
        wr(8'h0C, 32'h190);    // compare b 400
        wr(8'h14, 32'h120);    // a: set on a up, clear on b up
        wr(8'h18, 32'h3);      // b: invert at zero
        wr(8'h00, 32'h6);      // run, up count
        measure(3700, 601, 200, 1202, 601);
        wr(8'h08, 32'h64);     // compare a 100, shadowed until zero
        measure(1300, 601, 300, 1202, 601);
    endtask
    task automatic t_sym();
        wr(8'h08, 32'h15E);    // compare a 350
        wr(8'h0C, 32'h190);    // compare b 400, a high 250 ticks and b low 200 ticks each side of period
        wr(8'h14, 32'h60);     // a: set on a up, clear on a down
        wr(8'h18, 32'h900);    // b: clear on b up, set on b down
        wr(8'h00, 32'h7);      // run, up-down count
        measure(3700, 1200, 500, 1200, 800);
    endtask
    task automatic t_asym();
        wr(8'h08, 32'hFA);     // compare a 250
        wr(8'h0C, 32'h1C2);    // compare b 450
        wr(8'h18, 32'h9);      // b: clear at zero, set at period
        wr(8'h14, 32'h420);    // a: set on a up, clear on b down
        measure(3700, 1200, 500, 1200, 600);
        wr(8'h14, 32'h810);    // swapped actions make it active low
        measure(3700, 1200, 700, 1200, 600);
        // freeze across the period event that output b would act on,
        // so a leak of ce shows in the checker and in the count below
        ce <= 1'h0;            // frozen outputs are judged by the checker
        repeat (80) @(posedge pclk);
        ce <= 1'h1;
        rdc(8'h1C, 32'h0000021A); // count 538 rising, both outputs low
    endtask

    initial begin
        presetn = 1'h0;
        ce = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        t_regs();
        t_up();
        t_sym();
        t_asym();
        report_and_stop();
    end
endmodule
